// ==== dual_timer_counter.sv ====
// Two timer/counters plus external request flags sharing one control register.
// Assumes the core drives machine_tick and the vector acknowledges on pclk;
// count and request pins are asynchronous and are synchronised here.
//
// Function
// - Overflow flags bits 7 and 5 set on unit overflow, cleared on vectoring.
// - Run bits 6 and 4 switch unit 1 and unit 0 on and off.
// - Request flags bits 3 and 1 set by falling edge or low level on pin.
// - Trigger bits 2 and 0: one selects falling edge, zero selects low level.
// - Each unit has high and low 8-bit registers, separate or joined by mode.
// - Mode 0 is 13 bits: high byte plus low five bits; top three idle.
// - Overflow flag sets when the count rolls from all ones to zero.
// - Counting only while run is 1 and gate is 0 or request pin high.
// - Setting a run bit leaves the count registers untouched.
// - Mode 1 counts all 16 bits of high and low registers.
// - Mode 2 counts low byte, reloads it from high byte on overflow.
// - Unit 1 in mode 3 holds its count as if run were cleared.
// - Unit 0 mode 3: low byte is an 8-bit counter with unit 0 controls.
// - Unit 0 mode 3: high byte counts machine cycles under unit 1 run and flag.
// - With unit 0 in mode 3, unit 1 runs but cannot raise its own flag.
// - Mode bits: 00 prescaled, 01 16-bit, 10 auto-reload, 11 stop or split.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module dual_timer_counter (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Core side
	input wire logic machine_tick,
	input wire logic vector_ack_unit0,
	input wire logic vector_ack_unit1,
	input wire logic vector_ack_xline0,
	input wire logic vector_ack_xline1,
	output logic [3:0] request_flags,
	output logic unit1_rollover,
	output logic irq,
	// Pins
	input wire logic unit0_count_pin,
	input wire logic unit1_count_pin,
	input wire logic ext_request_pin_0,
	input wire logic ext_request_pin_1
);
	import timer_pkg::*;

	function automatic count_t step(input count_mode_t m, input logic [7:0] hi, input logic [7:0] lo);
		count_t r;
		r.ovf = 1'b0;
		r.high = hi;
		r.low = lo;
		unique case (m)
			MODE_PRESCALE: begin
				r.low = {lo[7:5], 5'(lo[4:0] + 5'h01)};
				if (lo[4:0] == 5'h1F) begin
					r.high = 8'(hi + 8'h01);
					r.ovf = (hi == 8'hFF);
				end
			end
			MODE_WIDE: begin
				{r.high, r.low} = 16'({hi, lo} + 16'h0001);
				r.ovf = ({hi, lo} == 16'hFFFF);
			end
			MODE_RELOAD: begin
				r.low = (lo == 8'hFF) ? hi : 8'(lo + 8'h01);
				r.ovf = (lo == 8'hFF);
			end
			MODE_SPLIT: begin
				r.low = 8'(lo + 8'h01);
				r.ovf = (lo == 8'hFF);
			end
		endcase
		return r;
	endfunction : step

	// Pin synchronisers: order is u0 pin, u1 pin, request 0, request 1
	logic [3:0] sync1_q;
	logic [3:0] sync2_q;
	logic [3:0] prev_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= 4'hF;
			sync2_q <= 4'hF;
			prev_q <= 4'hF;
		end else begin
			sync1_q <= {ext_request_pin_1, ext_request_pin_0, unit1_count_pin, unit0_count_pin};
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end
	wire logic [3:0] pin_fall = prev_q & ~sync2_q;
	wire logic xpin0 = sync2_q[2];
	wire logic xpin1 = sync2_q[3];

	// Registers
	logic [7:0] ctrl_q;
	logic [7:0] ctrl_d;
	logic [7:0] mode_q;
	logic [7:0] u0_lo_q;
	logic [7:0] u0_lo_d;
	logic [7:0] u0_hi_q;
	logic [7:0] u0_hi_d;
	logic [7:0] u1_lo_q;
	logic [7:0] u1_lo_d;
	logic [7:0] u1_hi_q;
	logic [7:0] u1_hi_d;
	logic [3:0] status_q;
	logic [3:0] enable_q;
	logic [31:0] prdata_q;
	logic rollover_q;

	// APB decode
	wire logic [9:0] idx = paddr[11:2];
	wire logic hit_ctrl = (idx == IDX_CONTROL);
	wire logic hit_mode = (idx == IDX_MODE);
	wire logic hit_u0_lo = (idx == IDX_U0_LOW);
	wire logic hit_u1_lo = (idx == IDX_U1_LOW);
	wire logic hit_u0_hi = (idx == IDX_U0_HIGH);
	wire logic hit_u1_hi = (idx == IDX_U1_HIGH);
	wire logic hit_stat = (idx == IDX_IRQ_STATUS);
	wire logic hit_clr = (idx == IDX_IRQ_CLEAR);
	wire logic hit_en = (idx == IDX_IRQ_ENABLE);
	wire logic mapped = hit_ctrl | hit_mode | hit_u0_lo | hit_u1_lo | hit_u0_hi | hit_u1_hi
		| hit_stat | hit_clr | hit_en;
	wire logic wr = psel & penable & pwrite & mapped;
	wire logic [7:0] wbyte = pwdata[7:0];
	wire logic wr_ctrl = wr & hit_ctrl;

	// Zero wait states; read data is captured in the setup cycle
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	wire logic [7:0] rd_byte = hit_ctrl ? ctrl_q
		: hit_mode ? mode_q
		: hit_u0_lo ? u0_lo_q
		: hit_u1_lo ? u1_lo_q
		: hit_u0_hi ? u0_hi_q
		: hit_u1_hi ? u1_hi_q
		: hit_stat ? {4'h0, status_q}
		: hit_en ? {4'h0, enable_q}
		: 8'h00;

	// Configuration fields
	wire unit_cfg_t cfg0 = mode_q[MODE_U0_LSB +: 4];
	wire unit_cfg_t cfg1 = mode_q[MODE_U1_LSB +: 4];
	wire logic run0 = ctrl_q[BIT_U0_RUN];
	wire logic run1 = ctrl_q[BIT_U1_RUN];
	wire logic split0 = (cfg0.mode == MODE_SPLIT);

	// Count sources and gating
	wire logic src0 = cfg0.count_pin ? pin_fall[0] : machine_tick;
	wire logic src1 = cfg1.count_pin ? pin_fall[1] : machine_tick;
	wire logic go0 = src0 & run0 & (~cfg0.gate | xpin0);
	wire logic go1 = src1 & run1 & (~cfg1.gate | xpin1) & (cfg1.mode != MODE_SPLIT);
	wire logic go0_hi = split0 & machine_tick & run1;

	wire count_t next0 = step(cfg0.mode, u0_hi_q, u0_lo_q);
	wire count_t next1 = step(cfg1.mode, u1_hi_q, u1_lo_q);
	wire logic ovf0 = go0 & next0.ovf;
	wire logic ovf0_hi = go0_hi & (u0_hi_q == 8'hFF);
	wire logic ovf1 = go1 & next1.ovf;

	// Unit 0 count, a software write wins over counting
	always_comb begin
		u0_lo_d = u0_lo_q;
		u0_hi_d = u0_hi_q;
		if (go0) begin
			u0_lo_d = next0.low;
			if (!split0) begin
				u0_hi_d = next0.high;
			end
		end
		if (go0_hi) begin
			u0_hi_d = 8'(u0_hi_q + 8'h01);
		end
		if (wr & hit_u0_lo) begin
			u0_lo_d = wbyte;
		end
		if (wr & hit_u0_hi) begin
			u0_hi_d = wbyte;
		end
	end

	// Unit 1 count; mode 3 stops it through go1
	always_comb begin
		u1_lo_d = u1_lo_q;
		u1_hi_d = u1_hi_q;
		if (go1) begin
			u1_lo_d = next1.low;
			u1_hi_d = next1.high;
		end
		if (wr & hit_u1_lo) begin
			u1_lo_d = wbyte;
		end
		if (wr & hit_u1_hi) begin
			u1_hi_d = wbyte;
		end
	end

	// Flag sets; unit 1 flag belongs to the unit 0 high byte in split mode
	wire logic set_ovf0 = ovf0;
	wire logic set_ovf1 = split0 ? ovf0_hi : ovf1;
	wire logic trig0 = ctrl_q[BIT_X0_TRIG];
	wire logic trig1 = ctrl_q[BIT_X1_TRIG];

	// Control register; hardware set wins over clear. Run bits
	// are plain storage so starting a unit never touches its count.
	always_comb begin
		ctrl_d = wr_ctrl ? wbyte : ctrl_q;
		if (!wr_ctrl && vector_ack_unit0) begin
			ctrl_d[BIT_U0_OVF] = 1'b0;
		end
		if (!wr_ctrl && vector_ack_unit1) begin
			ctrl_d[BIT_U1_OVF] = 1'b0;
		end
		if (!wr_ctrl && vector_ack_xline0 && trig0) begin
			ctrl_d[BIT_X0_REQ] = 1'b0;
		end
		if (!wr_ctrl && vector_ack_xline1 && trig1) begin
			ctrl_d[BIT_X1_REQ] = 1'b0;
		end
		if (set_ovf0) begin
			ctrl_d[BIT_U0_OVF] = 1'b1;
		end
		if (set_ovf1) begin
			ctrl_d[BIT_U1_OVF] = 1'b1;
		end
		// Edge type latches the fall; level type mirrors the inverted pin
		if (trig0) begin
			ctrl_d[BIT_X0_REQ] = ctrl_d[BIT_X0_REQ] | pin_fall[2];
		end else begin
			ctrl_d[BIT_X0_REQ] = ~xpin0;
		end
		if (trig1) begin
			ctrl_d[BIT_X1_REQ] = ctrl_d[BIT_X1_REQ] | pin_fall[3];
		end else begin
			ctrl_d[BIT_X1_REQ] = ~xpin1;
		end
	end

	// Sticky interrupt status; a new event beats a simultaneous clear
	wire logic [3:0] events = {
		ctrl_d[BIT_X1_REQ] & ~ctrl_q[BIT_X1_REQ],
		ctrl_d[BIT_X0_REQ] & ~ctrl_q[BIT_X0_REQ],
		set_ovf1,
		set_ovf0
	};
	wire logic [3:0] clr_mask = (wr & hit_clr) ? wbyte[3:0] : 4'h0;
	wire logic [3:0] status_d = (status_q & ~clr_mask) | events;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= RST_CONTROL;
			mode_q <= RST_MODE;
			status_q <= RST_IRQ;
			enable_q <= RST_IRQ;
		end else begin
			ctrl_q <= ctrl_d;
			mode_q <= (wr & hit_mode) ? wbyte : mode_q;
			status_q <= status_d;
			enable_q <= (wr & hit_en) ? wbyte[3:0] : enable_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			u0_lo_q <= RST_COUNT;
			u0_hi_q <= RST_COUNT;
			u1_lo_q <= RST_COUNT;
			u1_hi_q <= RST_COUNT;
		end else begin
			u0_lo_q <= u0_lo_d;
			u0_hi_q <= u0_hi_d;
			u1_lo_q <= u1_lo_d;
			u1_hi_q <= u1_hi_d;
		end
	end

	// Unit 1 rollover stays visible for baud use even in split mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
			rollover_q <= 1'b0;
		end else begin
			prdata_q <= (psel & ~penable) ? {24'h00_0000, rd_byte} : prdata_q;
			rollover_q <= ovf1;
		end
	end

	assign prdata = prdata_q;
	assign unit1_rollover = rollover_q;
	assign request_flags = {ctrl_q[BIT_X1_REQ], ctrl_q[BIT_X0_REQ], ctrl_q[BIT_U1_OVF], ctrl_q[BIT_U0_OVF]};
	assign irq = |(status_q & enable_q);

endmodule : dual_timer_counter
`default_nettype wire

// ==== timer_pkg.sv ====
// Package for the dual timer/counter with external request flags.
// Assumes a 32-bit APB slave on pclk; register indices map to byte address index*4.
package timer_pkg;

	// Register indices (byte address is four times the index)
	localparam logic [9:0] IDX_CONTROL = 10'h088;
	localparam logic [9:0] IDX_MODE = 10'h089;
	localparam logic [9:0] IDX_U0_LOW = 10'h08A;
	localparam logic [9:0] IDX_U1_LOW = 10'h08B;
	localparam logic [9:0] IDX_U0_HIGH = 10'h08C;
	localparam logic [9:0] IDX_U1_HIGH = 10'h08D;
	localparam logic [9:0] IDX_IRQ_STATUS = 10'h090;
	localparam logic [9:0] IDX_IRQ_CLEAR = 10'h091;
	localparam logic [9:0] IDX_IRQ_ENABLE = 10'h092;

	// Control register bit positions
	localparam int BIT_U1_OVF = 7;
	localparam int BIT_U1_RUN = 6;
	localparam int BIT_U0_OVF = 5;
	localparam int BIT_U0_RUN = 4;
	localparam int BIT_X1_REQ = 3;
	localparam int BIT_X1_TRIG = 2;
	localparam int BIT_X0_REQ = 1;
	localparam int BIT_X0_TRIG = 0;

	// Mode register: unit 1 in the upper nibble, unit 0 in the lower
	localparam int MODE_U1_LSB = 4;
	localparam int MODE_U0_LSB = 0;

	// Interrupt status bit positions
	localparam int EV_U0_OVF = 0;
	localparam int EV_U1_OVF = 1;
	localparam int EV_X0_REQ = 2;
	localparam int EV_X1_REQ = 3;

	// Reset values
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [7:0] RST_COUNT = 8'h00;
	localparam logic [3:0] RST_IRQ = 4'h0;

	typedef enum logic [1:0] {
		MODE_PRESCALE,
		MODE_WIDE,
		MODE_RELOAD,
		MODE_SPLIT
	} count_mode_t;

	// One nibble of the mode register
	typedef struct packed {
		logic gate;
		logic count_pin;
		count_mode_t mode;
	} unit_cfg_t;

	// Result of one counting step
	typedef struct packed {
		logic ovf;
		logic [7:0] high;
		logic [7:0] low;
	} count_t;

endpackage : timer_pkg

// ==== timer_props.sv ====
// Checker: APB answer, flag and interrupt relations at the top ports.
// Mirrors mode, trigger and enable writes; assumes aligned addresses.
`timescale 1ns/100ps
`default_nettype none
module timer_props
	import timer_pkg::*;
(
	// Clock, reset, APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	// Core side and pin
	input wire logic machine_tick,
	input wire logic vector_ack_unit0,
	input wire logic [3:0] request_flags,
	input wire logic unit1_rollover,
	input wire logic irq,
	input wire logic ext_request_pin_0
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic [9:0] idx = paddr[11:2];
	wire logic wr_ok = psel && penable && pwrite;
	wire logic ctl_wr = wr_ok && idx == IDX_CONTROL;
	logic [7:0] mode_q;
	logic [3:0] en_q;
	logic trig_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= RST_MODE;
			en_q <= RST_IRQ;
			trig_q <= 1'b0;
		end else begin
			if (wr_ok && idx == IDX_MODE)
				mode_q <= pwdata[7:0];
			if (wr_ok && idx == IDX_IRQ_ENABLE)
				en_q <= pwdata[3:0];
			if (ctl_wr)
				trig_q <= pwdata[BIT_X0_TRIG];
		end
	end
	// Five samples leave room for the two sync stages
	sequence s_x0_low; (!trig_q && !ext_request_pin_0) [*5]; endsequence
	sequence s_x0_high; (!trig_q && ext_request_pin_0) [*5]; endsequence
	property p_pready; pready; endproperty
	property p_sl_bad; psel && penable && idx > IDX_IRQ_ENABLE |-> pslverr; endproperty
	property p_x0_set; s_x0_low |-> request_flags[2]; endproperty
	property p_x0_clr; s_x0_high |-> !request_flags[2]; endproperty
	property p_ack_u0; vector_ack_unit0 && !machine_tick && !ctl_wr && !mode_q[2] |=> !request_flags[0]; endproperty
	property p_u0_rise; $rose(request_flags[0]) && !mode_q[2] |-> $past(machine_tick) || $past(ctl_wr); endproperty
	property p_u1_hold; mode_q[5:4] == 2'b11 && $past(mode_q[5:4]) == 2'b11 |-> !unit1_rollover; endproperty
	property p_irq_mask; en_q == 4'h0 |-> !irq; endproperty
	a_pready: assert property (p_pready) else $error("pready low");
	a_sl_bad: assert property (p_sl_bad) else $error("no error on unmapped access");
	a_x0_set: assert property (p_x0_set) else $error("level request not flagged");
	a_x0_clr: assert property (p_x0_clr) else $error("level flag not following pin");
	a_ack_u0: assert property (p_ack_u0) else $error("vector left unit 0 flag set");
	a_u0_rise: assert property (p_u0_rise) else $error("unit 0 flag set without tick");
	a_u1_hold: assert property (p_u1_hold) else $error("unit 1 rolled over while stopped");
	a_irq_mask: assert property (p_irq_mask) else $error("irq with nothing enabled");
endmodule : timer_props
bind dual_timer_counter timer_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .machine_tick(machine_tick), .vector_ack_unit0(vector_ack_unit0),
	.request_flags(request_flags), .unit1_rollover(unit1_rollover), .irq(irq),
	.ext_request_pin_0(ext_request_pin_0));
`default_nettype wire

// ==== pin_model.sv ====
// Far-side pins: count and request lines 0 and 1, idle high.
// Bench calls its tasks with a line index; each level outlasts the synchroniser.
`timescale 1ns/100ps
`default_nettype none
module pin_model (
	// Clock and pins
	input wire logic pclk,
	output var logic [1:0] cnt = 2'b11,
	output var logic [1:0] xreq = 2'b11
);
	task pulse(input int k);
		@(posedge pclk);
		cnt[k] <= 1'b0;
		repeat (3) @(posedge pclk);
		cnt[k] <= 1'b1;
		repeat (4) @(posedge pclk);
	endtask : pulse
	// Level source holds the driven value until the next call
	task req(input int k, input logic v);
		@(posedge pclk);
		xreq[k] <= v;
		repeat (6) @(posedge pclk);
	endtask : req
endmodule : pin_model
`default_nettype wire

// ==== dual_timer_counter_ext_int_tb.sv ====
// Bench: APB master, tick and vector strobes, scenario tasks.
// Assumes the pin model on the pins and a zero-wait slave.
`timescale 1ns/100ps
`default_nettype none
module dual_timer_counter_ext_int_tb;
	import timer_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [4:0] sb = 5'h00;
	logic [31:0] prdata;
	logic pready, pslverr, irq, err;
	logic [3:0] flags;
	logic [1:0] cnt, xreq;
	logic [7:0] rq;
	logic roll;
	int n_roll = 0;
	int fail_count = 0;
	int n_tests = 0;
	always #5 pclk = ~pclk;
	pin_model pins (.pclk(pclk), .cnt(cnt), .xreq(xreq));
	// Rollover is a one-cycle pulse, so it is counted here
	always @(posedge pclk) begin
		if (roll === 1'b1) begin
			n_roll <= n_roll + 1;
		end
	end
	dual_timer_counter uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .machine_tick(sb[4]), .vector_ack_unit0(sb[0]), .vector_ack_unit1(sb[1]),
		.vector_ack_xline0(sb[2]), .vector_ack_xline1(sb[3]), .request_flags(flags),
		.unit1_rollover(roll), .irq(irq), .unit0_count_pin(cnt[0]), .unit1_count_pin(cnt[1]),
		.ext_request_pin_0(xreq[0]), .ext_request_pin_1(xreq[1]));
	task xfer(input logic w, input logic [9:0] i, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rq = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task wr(input logic [9:0] i, input logic [7:0] d);
		xfer(1'b1, i, d);
	endtask : wr
	task chk(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value at %0t: got %h, expected %h", $time, g, e);
		end
	endtask : chk
	task rc(input logic [9:0] i, input logic [7:0] e);
		xfer(1'b0, i, 8'h00);
		chk(rq, e);
	endtask : rc
	// Ends at a falling edge so outputs have settled
	task strobe(input logic [4:0] m);
		@(posedge pclk);
		sb <= m;
		@(posedge pclk);
		sb <= 5'h00;
		@(negedge pclk);
	endtask : strobe
	task st(input logic [4:0] e);
		@(negedge pclk);
		chk({3'h0, irq, flags}, {3'h0, e});
	endtask : st
	task run_mode(input logic [7:0] m, h, l, eh, el, mk, ec);
		wr(IDX_CONTROL, 8'h00);
		wr(IDX_MODE, m);
		wr(IDX_U0_HIGH, h);
		wr(IDX_U0_LOW, l);
		wr(IDX_CONTROL, 8'h10);
		strobe(5'h10);
		rc(IDX_U0_HIGH, eh);
		xfer(1'b0, IDX_U0_LOW, 8'h00);
		chk(rq & mk, el);
		rc(IDX_CONTROL, ec);
	endtask : run_mode
	task t_irq;
		rc(IDX_MODE, RST_MODE);
		xfer(1'b0, 10'h3FF, 8'h00);
		chk({7'h00, err}, 8'h01);
		wr(IDX_MODE, 8'h01);
		wr(IDX_U0_HIGH, 8'hFF);
		wr(IDX_U0_LOW, 8'hFF);
		wr(IDX_CONTROL, 8'h10);
		rc(IDX_U0_LOW, 8'hFF);
		strobe(5'h10);
		st(5'h01);
		wr(IDX_IRQ_ENABLE, 8'h01);
		st(5'h11);
		wr(IDX_IRQ_CLEAR, 8'h01);
		st(5'h01);
		strobe(5'h01);
		st(5'h00);
		wr(IDX_CONTROL, 8'h00);
		strobe(5'h10);
		rc(IDX_U0_LOW, 8'h00);
		wr(IDX_IRQ_ENABLE, 8'h00);
		$display("irq done");
	endtask : t_irq
	task t_modes;
		run_mode(8'h01, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'h30);
		run_mode(8'h01, 8'h12, 8'hFF, 8'h13, 8'h00, 8'hFF, 8'h10);
		run_mode(8'h00, 8'h12, 8'hFF, 8'h13, 8'h00, 8'h1F, 8'h10);
		run_mode(8'h02, 8'h40, 8'hFF, 8'h40, 8'h40, 8'hFF, 8'h30);
		$display("modes done");
	endtask : t_modes
	task t_gate;
		wr(IDX_CONTROL, 8'h00);
		wr(IDX_MODE, 8'h09);
		wr(IDX_U0_LOW, 8'h00);
		wr(IDX_CONTROL, 8'h10);
		pins.req(0, 1'b0);
		strobe(5'h10);
		rc(IDX_U0_LOW, 8'h00);
		pins.req(0, 1'b1);
		strobe(5'h10);
		rc(IDX_U0_LOW, 8'h01);
		wr(IDX_MODE, 8'h05);
		pins.pulse(0);
		strobe(5'h10);
		rc(IDX_U0_LOW, 8'h02);
		$display("gate done");
	endtask : t_gate
	task t_ext;
		wr(IDX_CONTROL, 8'h01);
		pins.req(0, 1'b0);
		pins.req(0, 1'b1);
		st(5'h04);
		strobe(5'h04);
		st(5'h00);
		wr(IDX_CONTROL, 8'h00);
		pins.req(0, 1'b0);
		strobe(5'h04);
		st(5'h04);
		pins.req(0, 1'b1);
		st(5'h00);
		$display("ext done");
	endtask : t_ext
	task t_split;
		wr(IDX_MODE, 8'h33);
		wr(IDX_U0_HIGH, 8'hFF);
		wr(IDX_U1_HIGH, 8'hFF);
		wr(IDX_U1_LOW, 8'hFF);
		wr(IDX_CONTROL, 8'h40);
		strobe(5'h10);
		rc(IDX_U0_HIGH, 8'h00);
		rc(IDX_U1_LOW, 8'hFF);
		chk(8'(n_roll), 8'h00);
		st(5'h02);
		strobe(5'h02);
		st(5'h00);
		$display("split done");
	endtask : t_split
	// Unit 1 on its count pin, line 1 edge requests, then rollover under split
	task t_unit1;
		wr(IDX_CONTROL, 8'h00);
		wr(IDX_MODE, 8'h50);
		wr(IDX_U1_HIGH, 8'hFF);
		wr(IDX_U1_LOW, 8'hFF);
		wr(IDX_CONTROL, 8'h44);
		pins.pulse(1);
		chk(8'(n_roll), 8'h01);
		rc(IDX_U1_HIGH, 8'h00);
		rc(IDX_U1_LOW, 8'h00);
		pins.req(1, 1'b0);
		pins.req(1, 1'b1);
		st(5'h0A);
		strobe(5'h0A);
		st(5'h00);
		wr(IDX_U1_HIGH, 8'hFF);
		wr(IDX_U1_LOW, 8'hFF);
		wr(IDX_MODE, 8'h53);
		pins.pulse(1);
		chk(8'(n_roll), 8'h02);
		st(5'h00);
		$display("unit1 done");
	endtask : t_unit1
	task wrap_up;
		$display("comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_irq();
		t_modes();
		t_gate();
		t_ext();
		t_split();
		t_unit1();
		wrap_up();
	end
	// Tests need about 350 cycles; 10000 is ample
	initial begin
		#100000;
		fail_count++;
		wrap_up();
	end
endmodule : dual_timer_counter_ext_int_tb
`default_nettype wire
